/* rtl/sma_pkg.sv */
// package for sync measure and align: register map, resets, timing counts
package sma_pkg;
	// register subaddresses
	localparam logic [7:0] ADDR_VH_OFFSET = 8'h35;
	localparam logic [7:0] ADDR_PASS_CTRL = 8'h36;
	localparam logic [7:0] ADDR_LINES_LO = 8'h37;
	localparam logic [7:0] ADDR_LINES_HI = 8'h38;
	localparam logic [7:0] ADDR_CLKS_LO = 8'h39;
	localparam logic [7:0] ADDR_CLKS_HI = 8'h3A;
	localparam logic [7:0] ADDR_HS_WIDTH = 8'h3B;
	localparam logic [7:0] ADDR_VS_WIDTH = 8'h3C;
	localparam logic [7:0] ADDR_JITTER_TOL = 8'h3D;
	localparam logic [7:0] ADDR_AV_START_LO = 8'h40;
	localparam logic [7:0] ADDR_AV_START_HI = 8'h41;
	// reset values
	localparam logic [7:0] RST_VH_OFFSET = 8'h10;
	localparam logic [3:0] RST_PASS_CTRL = 4'h0;
	localparam logic [6:0] RST_JITTER_TOL = 7'h03;
	localparam logic [12:0] RST_AV_START = 13'h012C;
	localparam logic RST_BLANK_GATE = 1'b0;
	// field positions in the passthrough control register
	localparam int BIT_HS_PASS = 0;
	localparam int BIT_VS_PASS = 1;
	localparam int BIT_HORIZONTAL_OUT_INVERT = 2;
	localparam int BIT_VERTICAL_OUT_INVERT = 3;
	// field positions in the upper status and start bytes
	localparam int BIT_PROG = 5;
	localparam int BIT_PSEUDO = 6;
	localparam int BIT_BLANK_GATE = 5;
	// alignment delay line: centre tap is zero offset
	localparam int ALIGN_CENTRE = 128;
	localparam int ALIGN_DEPTH = 256;
	// embedded start code leads the window by this many pixels
	localparam logic [12:0] SAV_LEAD_PIX = 13'h0004;
	// internal reference derived from the core clock
	localparam int CORE_CLK_HZ = 100_000_000;
	localparam int INT_REF_HZ = 6_500_000;
	localparam int INT_REF_DIV = CORE_CLK_HZ / INT_REF_HZ;
	localparam logic [3:0] INT_REF_WRAP = 4'(INT_REF_DIV - 1);

	// frame measurement snapshot
	typedef struct packed {
		logic [11:0] lines;
		logic [11:0] clks;
		logic [7:0] hs_width;
		logic [4:0] vs_width;
		logic pseudo;
		logic prog;
	} sma_status_t;
endpackage : sma_pkg

/* rtl/sma_sync_measure_align.sv */
// sync alignment, bypass and input-format measurement block
module sma_sync_measure_align (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// sync pins and reference
	input wire logic hsync_pin,
	input wire logic vsync_pin,
	input wire logic external_reference_clock,
	input wire logic ref_select_external,
	// pixel timing from the same clock domain
	input wire logic pixel_strobe,
	input wire logic vertical_blank_interval,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// aligned outputs
	output logic hsync_out,
	output logic vsync_out,
	output logic field_id_out,
	output logic active_video_window,
	output logic sav_insert
);
	typedef struct packed {
		logic hs_m, hs_s, hs_d;
		logic vs_m, vs_s, vs_d;
		logic ek_m, ek_s, ek_d;
		logic [3:0] div;
		logic ref_tick;
		logic [7:0] off;
		logic [3:0] ctrl;
		logic [6:0] tol;
		logic [12:0] avs;
		logic [7:0] avs_lo;
		logic gate;
		logic [11:0] lclk, lmax, lprev, lines;
		logic [7:0] hsw_cnt, hsw_last;
		logic [4:0] vsw_cnt, vsw_last;
		logic pseudo_seen, field, field_prev;
		sma_pkg::sma_status_t stat;
		logic [128:0] hsh;
		logic [sma_pkg::ALIGN_DEPTH-1:0] vsh, fsh;
		logic [12:0] pix;
		logic hs_o, vs_o, fid_o, av_o, sav_o;
		logic [7:0] rdata;
	} sma_state_t;

	sma_state_t s_r, s_nxt;
	logic [7:0] tap;
	logic hs_rise, hs_fall, vs_rise, vs_fall, lead, short_line;
	logic [12:0] pix_n;

	function automatic logic [7:0] align_tap(input logic [7:0] off);
		return {~off[7], off[6:0]};
	endfunction : align_tap

	function automatic logic [11:0] sat_inc12(input logic [11:0] v);
		return (v == 12'hFFF) ? v : v + 12'h001;
	endfunction : sat_inc12

	always_comb begin
		s_nxt = s_r;
		// first stage never feeds logic; second and third stages do
		s_nxt.hs_m = hsync_pin;
		s_nxt.hs_s = s_r.hs_m;
		s_nxt.hs_d = s_r.hs_s;
		s_nxt.vs_m = vsync_pin;
		s_nxt.vs_s = s_r.vs_m;
		s_nxt.vs_d = s_r.vs_s;
		s_nxt.ek_m = external_reference_clock;
		s_nxt.ek_s = s_r.ek_m;
		s_nxt.ek_d = s_r.ek_s;
		hs_rise = s_r.hs_s && !s_r.hs_d;
		hs_fall = !s_r.hs_s && s_r.hs_d;
		vs_rise = s_r.vs_s && !s_r.vs_d;
		vs_fall = !s_r.vs_s && s_r.vs_d;
		short_line = hs_rise && s_r.lprev != 12'h000 &&
			({1'b0, s_r.lclk} + {6'h00, s_r.tol}) < {1'b0, s_r.lprev};
		s_nxt.div = (s_r.div == sma_pkg::INT_REF_WRAP) ? 4'h0 : s_r.div + 4'h1;
		s_nxt.ref_tick = ref_select_external ? (s_r.ek_s && !s_r.ek_d)
			: (s_r.div == sma_pkg::INT_REF_WRAP);

		if (s_r.hs_s && s_r.ref_tick && s_r.hsw_cnt != 8'hFF) begin
			s_nxt.hsw_cnt = s_r.hsw_cnt + 8'h01;
		end
		if (hs_fall) begin
			s_nxt.hsw_last = s_r.hsw_cnt;
		end
		if (s_r.ref_tick) begin
			s_nxt.lclk = sat_inc12(s_r.lclk);
		end
		if (hs_rise) begin
			s_nxt.hsw_cnt = 8'h00;
			s_nxt.lclk = 12'h000;
			s_nxt.lprev = s_r.lclk;
			if (s_r.lclk > s_r.lmax) begin
				s_nxt.lmax = s_r.lclk;
			end
			s_nxt.lines = sat_inc12(s_r.lines);
			if (short_line) begin
				s_nxt.pseudo_seen = 1'b1;
			end
			if (s_r.vs_s && s_r.vsw_cnt != 5'h1F) begin
				s_nxt.vsw_cnt = s_r.vsw_cnt + 5'h01;
			end
		end
		if (vs_fall) begin
			s_nxt.vsw_last = s_r.vsw_cnt;
		end
		if (vs_rise) begin
			s_nxt.stat.lines = s_r.lines;
			s_nxt.stat.clks = s_r.lmax;
			s_nxt.stat.hs_width = s_r.hsw_last;
			s_nxt.stat.vs_width = s_r.vsw_last;
			s_nxt.stat.pseudo = s_r.pseudo_seen;
			// a line edge in this same cycle opens the new frame
			s_nxt.lines = {11'h000, hs_rise};
			s_nxt.lmax = 12'h000;
			s_nxt.pseudo_seen = short_line;
			s_nxt.vsw_cnt = {4'h0, hs_rise};
			// mid-line vsync marks the odd field
			s_nxt.field = s_r.lclk > {1'b0, s_r.lprev[11:1]};
			s_nxt.field_prev = s_r.field;
			s_nxt.stat.prog = (s_nxt.field == s_r.field);
		end

		tap = (s_r.ctrl[sma_pkg::BIT_HS_PASS] || s_r.ctrl[sma_pkg::BIT_VS_PASS])
			? 8'(sma_pkg::ALIGN_CENTRE) : align_tap(s_r.off);
		lead = 1'b0;
		pix_n = s_r.pix;
		if (pixel_strobe) begin
			s_nxt.hsh = {s_r.hsh[127:0], s_r.hs_s};
			s_nxt.vsh = {s_r.vsh[sma_pkg::ALIGN_DEPTH-2:0], s_r.vs_s};
			s_nxt.fsh = {s_r.fsh[sma_pkg::ALIGN_DEPTH-2:0], s_r.field};
			lead = s_r.hsh[127] && !s_r.hsh[128];
			// pixel zero at hsync leading edge
			pix_n = lead ? 13'h0000
				: ((s_r.pix == 13'h1FFF) ? s_r.pix : s_r.pix + 13'h0001);
		end
		s_nxt.pix = pix_n;
		s_nxt.sav_o = pixel_strobe && (pix_n == s_r.avs - sma_pkg::SAV_LEAD_PIX);
		s_nxt.av_o = (pix_n >= s_r.avs) &&
			!(s_r.gate && vertical_blank_interval);

		// hsync raw bypass, invert only in bypass
		s_nxt.hs_o = s_r.ctrl[sma_pkg::BIT_HS_PASS]
			? (s_r.hs_s ^ s_r.ctrl[sma_pkg::BIT_HORIZONTAL_OUT_INVERT]) : s_r.hsh[128];
		// vsync raw bypass, invert only in bypass
		s_nxt.vs_o = s_r.ctrl[sma_pkg::BIT_VS_PASS]
			? (s_r.vs_s ^ s_r.ctrl[sma_pkg::BIT_VERTICAL_OUT_INVERT]) : s_r.vsh[tap];
		// field id on the same tap
		s_nxt.fid_o = s_r.fsh[tap];

		// register writes
		if (reg_write) begin
			case (reg_addr)
				sma_pkg::ADDR_VH_OFFSET: s_nxt.off = reg_wdata;
				sma_pkg::ADDR_PASS_CTRL: s_nxt.ctrl = reg_wdata[3:0];
				sma_pkg::ADDR_JITTER_TOL: s_nxt.tol = reg_wdata[6:0];
				// low byte waits in a shadow
				sma_pkg::ADDR_AV_START_LO: s_nxt.avs_lo = reg_wdata;
				sma_pkg::ADDR_AV_START_HI: begin
					s_nxt.avs = {reg_wdata[4:0], s_r.avs_lo};
					s_nxt.gate = reg_wdata[sma_pkg::BIT_BLANK_GATE];
				end
				default: begin
				end
			endcase
		end
		// reads: unmapped and reserved bits answer zero
		if (reg_read) begin
			case (reg_addr)
				sma_pkg::ADDR_VH_OFFSET: s_nxt.rdata = s_r.off;
				sma_pkg::ADDR_PASS_CTRL: s_nxt.rdata = {4'h0, s_r.ctrl};
				sma_pkg::ADDR_LINES_LO: s_nxt.rdata = s_r.stat.lines[7:0];
				sma_pkg::ADDR_LINES_HI: s_nxt.rdata = {1'b0, s_r.stat.pseudo,
					s_r.stat.prog, 1'b0, s_r.stat.lines[11:8]};
				sma_pkg::ADDR_CLKS_LO: s_nxt.rdata = s_r.stat.clks[7:0];
				sma_pkg::ADDR_CLKS_HI: s_nxt.rdata = {4'h0, s_r.stat.clks[11:8]};
				sma_pkg::ADDR_HS_WIDTH: s_nxt.rdata = s_r.stat.hs_width;
				sma_pkg::ADDR_VS_WIDTH: s_nxt.rdata = {3'h0, s_r.stat.vs_width};
				sma_pkg::ADDR_JITTER_TOL: s_nxt.rdata = {1'b0, s_r.tol};
				sma_pkg::ADDR_AV_START_LO: s_nxt.rdata = s_r.avs[7:0];
				sma_pkg::ADDR_AV_START_HI: s_nxt.rdata = {2'h0, s_r.gate,
					s_r.avs[12:8]};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
			s_r.off <= sma_pkg::RST_VH_OFFSET;
			s_r.ctrl <= sma_pkg::RST_PASS_CTRL;
			s_r.tol <= sma_pkg::RST_JITTER_TOL;
			s_r.avs <= sma_pkg::RST_AV_START;
			s_r.avs_lo <= sma_pkg::RST_AV_START[7:0];
			s_r.gate <= sma_pkg::RST_BLANK_GATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign hsync_out = s_r.hs_o;
	assign vsync_out = s_r.vs_o;
	assign field_id_out = s_r.fid_o;
	assign active_video_window = s_r.av_o;
	assign sav_insert = s_r.sav_o;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_hs_fall;
		s_r.hs_d && !s_r.hs_s;
	endsequence
	sequence s_vs_rise;
		s_r.vs_s && !s_r.vs_d;
	endsequence
	sequence s_hi_write;
		reg_write && reg_addr == sma_pkg::ADDR_AV_START_HI;
	endsequence

	property p_hs_bypass;
		s_r.ctrl[sma_pkg::BIT_HS_PASS] |=>
			hsync_out == ($past(s_r.hs_s) ^ $past(s_r.ctrl[2]));
	endproperty
	a_hs_bypass: assert property (p_hs_bypass)
		else $error("hsync bypass output wrong");
	property p_vs_bypass;
		s_r.ctrl[sma_pkg::BIT_VS_PASS] |=>
			vsync_out == ($past(s_r.vs_s) ^ $past(s_r.ctrl[3]));
	endproperty
	a_vs_bypass: assert property (p_vs_bypass)
		else $error("vsync bypass output wrong");
	property p_vs_align;
		s_r.ctrl[1:0] == 2'b00 |=>
			vsync_out == $past(s_r.vsh[align_tap(s_r.off)]);
	endproperty
	a_vs_align: assert property (p_vs_align)
		else $error("vsync not on offset tap");
	property p_fid_align;
		s_r.ctrl[1:0] == 2'b00 |=>
			field_id_out == $past(s_r.fsh[align_tap(s_r.off)]);
	endproperty
	a_fid_align: assert property (p_fid_align)
		else $error("field id not on offset tap");
	property p_bypass_no_offset;
		s_r.ctrl[1:0] != 2'b00 |=> field_id_out == $past(s_r.fsh[128]);
	endproperty
	a_bypass_no_offset: assert property (p_bypass_no_offset)
		else $error("offset applied during bypass");
	property p_lo_no_commit;
		reg_write && reg_addr == sma_pkg::ADDR_AV_START_LO |=> $stable(s_r.avs);
	endproperty
	a_lo_no_commit: assert property (p_lo_no_commit)
		else $error("start moved on low byte write");
	property p_hi_commit;
		s_hi_write |=> s_r.avs == {$past(reg_wdata[4:0]), $past(s_r.avs_lo)};
	endproperty
	a_hi_commit: assert property (p_hi_commit)
		else $error("start not committed on upper byte");
	property p_sav_lead;
		sav_insert |-> s_r.pix == $past(s_r.avs) - sma_pkg::SAV_LEAD_PIX;
	endproperty
	a_sav_lead: assert property (p_sav_lead)
		else $error("start code not four pixels early");
	property p_blank_gate;
		s_r.gate && vertical_blank_interval |=> !active_video_window;
	endproperty
	a_blank_gate: assert property (p_blank_gate)
		else $error("window active in gated blanking");
	property p_frame_snapshot;
		!(s_r.vs_s && !s_r.vs_d) |=> $stable(s_r.stat);
	endproperty
	a_frame_snapshot: assert property (p_frame_snapshot)
		else $error("status changed mid frame");
	property p_line_snapshot;
		s_vs_rise |=> s_r.stat.lines == $past(s_r.lines);
	endproperty
	a_line_snapshot: assert property (p_line_snapshot)
		else $error("line count not captured");
	property p_hs_width;
		s_hs_fall |=> s_r.hsw_last == $past(s_r.hsw_cnt);
	endproperty
	a_hs_width: assert property (p_hs_width)
		else $error("hsync width not captured");
endmodule : sma_sync_measure_align

/* testbench/sma_sync_source.sv */
// sync source model: syncs, pixel strobe, blanking, reference clock
module sma_sync_source (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// frame shape
	input wire logic interlace,
	input wire logic pseudo,
	// source pins
	output logic hsync_pin,
	output logic vsync_pin,
	output logic pixel_strobe,
	output logic vertical_blank_interval,
	output logic external_reference_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cyc;
	logic [6:0] ph;
	logic [3:0] line;
	logic fld;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc <= 7'h00;
			line <= 4'h0;
			fld <= 1'b0;
		end else begin
			cyc <= cyc + 7'h01;
			if (cyc == 7'h7F) begin
				line <= (line == 4'hB) ? 4'h0 : line + 4'h1;
				if (line == 4'hB) begin
					fld <= interlace & ~fld;
				end
			end
		end
	end
	// odd field starts late in the line, giving two field phases
	assign ph = fld ? 7'h60 : 7'h20;
	// 128-clock lines, 8-pixel hsync, optional mid-line pseudo pulse
	assign hsync_pin = (cyc < 7'h10) ||
		(pseudo && line == 4'h5 && cyc[6:4] == 3'h4);
	assign vsync_pin = (line == 4'h0 && cyc >= ph) || line == 4'h1 ||
		line == 4'h2 || (line == 4'h3 && cyc < ph);
	assign vertical_blank_interval = line < 4'h4;
	assign pixel_strobe = cyc[0];
	// 25 MHz reference, under the 27 MHz ceiling
	assign external_reference_clock = cyc[1];
endmodule : sma_sync_source

/* testbench/tb_sync_measure_and_align.sv */
// self-checking bench for sync measure and align
module tb_sync_measure_and_align;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, arst_n, ref_select_external, reg_write, reg_read;
	logic interlace, pseudo, mon, hsync_pin, vsync_pin, pixel_strobe;
	logic vertical_blank_interval, external_reference_clock, field_id_out;
	logic hsync_out, vsync_out, active_video_window, sav_insert;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, c;
	logic [2:0] hh, vh, vb;
	int error_cnt, cmp_count, n0, n1, hv, hc, vc;

	sma_sync_source u_src (.core_clk(core_clk), .arst_n(arst_n),
		.interlace(interlace), .pseudo(pseudo), .hsync_pin(hsync_pin),
		.vsync_pin(vsync_pin), .pixel_strobe(pixel_strobe),
		.vertical_blank_interval(vertical_blank_interval),
		.external_reference_clock(external_reference_clock));
	sma_sync_measure_align u_dut (.core_clk(core_clk), .arst_n(arst_n),
		.hsync_pin(hsync_pin), .vsync_pin(vsync_pin),
		.external_reference_clock(external_reference_clock),
		.ref_select_external(ref_select_external),
		.pixel_strobe(pixel_strobe),
		.vertical_blank_interval(vertical_blank_interval),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .hsync_out(hsync_out),
		.vsync_out(vsync_out), .field_id_out(field_id_out),
		.active_video_window(active_video_window), .sav_insert(sav_insert));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen,
				exp);
		end
	endtask : check
	// measured counts may land one reference tick either side
	function automatic logic near(int a, int b);
		return a - b <= 1 && b - a <= 1;
	endfunction : near
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		check(d, e);
	endtask : rc
	task automatic frames(input int k);
		repeat (k * 1536) @(posedge core_clk);
	endtask : frames
	// cycles from a rise of a to the next rise of b
	task automatic gap(ref logic a, ref logic b, output int n);
		n = 0;
		while (a !== 1'b0) @(posedge core_clk);
		while (a !== 1'b1) @(posedge core_clk);
		while (b !== 1'b0 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		while (b !== 1'b1 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
	endtask : gap
	task automatic summarize();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// bypass path: three edges from pin to output
	always @(negedge core_clk) begin
		if (mon && c[0]) check(hsync_out, hh[2] ^ c[2]);
		if (mon && c[1]) check(vsync_out, vh[2] ^ c[3]);
		if (&vb && vertical_blank_interval && active_video_window) hv++;
		hh <= {hh[1:0], hsync_pin};
		vh <= {vh[1:0], vsync_pin};
		vb <= {vb[1:0], vertical_blank_interval};
		hc += int'(hsync_out);
		vc += int'(vsync_out);
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		error_cnt++;
		summarize();
	end

	initial begin
		{arst_n, ref_select_external, reg_write, reg_read} = 4'h0;
		{interlace, pseudo, mon} = 3'h0;
		{reg_addr, reg_wdata, c} = 24'h000000;
		{hh, vh, vb} = 9'h000;
		{error_cnt, cmp_count, hv, hc, vc} = '0;
		void'($urandom(32'h4330));
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rc(8'h35, 8'h10);
		rc(8'h36, 8'h00);
		rc(8'h3D, 8'h03);
		rc(8'h40, 8'h2C);
		rc(8'h41, 8'h01);
		rc(8'h3E, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(8'h35, v);
			rc(8'h35, v);
			wr(8'h3D, v);
			rc(8'h3D, {1'b0, v[6:0]});
		end
		// a random tolerance could flag clean lines as short
		wr(8'h3D, 8'h03);
		for (int i = 1; i < 16; i++) begin
			c = 8'(i);
			wr(8'h35, 8'($urandom));
			wr(8'h36, c);
			rc(8'h36, c);
			repeat (8) @(posedge core_clk);
			mon = 1'b1;
			repeat (300) @(posedge core_clk);
			mon = 1'b0;
		end
		// invert bits alone must leave polarity untouched
		wr(8'h36, 8'h0C);
		wr(8'h35, 8'h10);
		frames(1);
		hc = 0;
		vc = 0;
		frames(1);
		check(16'(hc), 16'h00C0);
		check(16'(vc), 16'h0180);
		wr(8'h36, 8'h00);
		wr(8'h3C, 8'h1F);
		frames(3);
		rc(8'h37, 8'h0C);
		rc(8'h38, 8'h20);
		rc(8'h3A, 8'h00);
		rc(8'h3C, 8'h03);
		rd(8'h39, v);
		check(16'(near(v, 9)), 16'h0001);
		rd(8'h3B, v);
		check(16'(near(v, 2)), 16'h0001);
		ref_select_external <= 1'b1;
		frames(3);
		rd(8'h39, v);
		check(16'(near(v, 32)), 16'h0001);
		rd(8'h3B, v);
		check(16'(near(v, 4)), 16'h0001);
		interlace <= 1'b1;
		frames(4);
		rc(8'h38, 8'h00);
		// field id must flip between successive aligned vsync pulses
		gap(vsync_pin, vsync_out, n0);
		repeat (4) @(posedge core_clk);
		v[0] = field_id_out;
		gap(vsync_pin, vsync_out, n0);
		repeat (4) @(posedge core_clk);
		check(16'(v[0] ^ field_id_out), 16'h0001);
		interlace <= 1'b0;
		pseudo <= 1'b1;
		frames(3);
		rc(8'h38, 8'h60);
		pseudo <= 1'b0;
		frames(3);
		rc(8'h38, 8'h20);
		gap(vsync_pin, vsync_out, n0);
		wr(8'h35, 8'hF0);
		gap(vsync_pin, vsync_out, n1);
		check(16'(near(n0 - n1, 64)), 16'h0001);
		wr(8'h40, 8'h14);
		wr(8'h41, 8'h00);
		gap(hsync_out, active_video_window, n0);
		wr(8'h40, 8'h1E);
		gap(hsync_out, active_video_window, n1);
		check(16'(n1 - n0), 16'h0000);
		wr(8'h41, 8'h00);
		gap(hsync_out, active_video_window, n1);
		check(16'(near(n1 - n0, 20)), 16'h0001);
		gap(sav_insert, active_video_window, n1);
		check(16'(near(n1, 8)), 16'h0001);
		hv = 0;
		frames(1);
		check(16'(hv > 0), 16'h0001);
		wr(8'h41, 8'h20);
		rc(8'h41, 8'h20);
		hv = 0;
		frames(1);
		check(16'(hv), 16'h0000);
		summarize();
	end
endmodule : tb_sync_measure_and_align
